/* src/cfg_slave.sv */
// Config slave: high-speed entry and exit, 16-bit protection register.
// Assumes asynchronous pins and many clocks per SCL phase.
// Notes on behaviour
// RL1 - Master code 00001xxx requests high speed
// RL2 - Master code sent at 1 MHz or slower
// RL3 - Master code is not acknowledged
// RL4 - Then high-speed filter, wait repeated start
// RL5 - Address byte acked, transfers at high speed
// RL6 - Stop or reset returns standard filters
// RL7 - Master chains high-speed work by restarts
// RL8 - Entry ignored during self-timed write
// RL9 - Polling only at standard rates
// RL10 - Register selected by device type 1011
// RL11 - Bits 3..1 match chip selects, bit0 direction
// RL12 - Only word bits 15,11,10 checked
// RL13 - Random read and byte write access
// RL14 - Upper data byte sent first
// RL15 - Bit 15 reports last read's correction
// RL16 - Bits 14..10 read zero
// RL17 - Bit 9 selects pin or zone protection
// RL18 - Bit 8 locks register forever; rst_n_i reloads UPPER_RESET and clears the lock
// RL19 - Lower byte bit n guards zone n
// RL20 - Two data bytes plus confirmation required
// RL21 - Confirmation 99h locks, 66h leaves open
// RL22 - Locked writes acked but ignored
// RL23 - Read wraps from lower to upper byte
`timescale 1ns/10ps
`default_nettype none
module cfg_slave
  import cfg_link_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Two-wire link
  cfg_link_if.slave       link,
  // Chip-select straps, memory core status and write-protect pin
  input  wire logic [2:0] chip_sel_i,
  input  wire logic       write_busy_i,
  input  wire logic       mem_read_done_i,
  input  wire logic       mem_read_ecc_i,
  input  wire logic       wp_pin_i,
  // Status and protection outputs
  output logic            hs_mode_o,
  output logic [7:0]      zone_block_o,
  output logic            cfg_write_o,
  output logic [15:0]     cfg_word_o
);
  // ==========================================================================
  // Synchronisers and filter
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_RECV  = 6'b000100,
    ST_SEND  = 6'b001000,
    ST_HSWT  = 6'b010000,
    ST_IGN   = 6'b100000
  } slave_st_e;

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [2:0] scl_hist;
  logic [2:0] sda_hist;
  logic       scl_f;
  logic       sda_f;
  logic       scl_d;
  logic       sda_d;

  // Two flops per pin before any logic
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  // RL4 filter depth switch: standard filter needs three equal samples
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_hist <= 3'h7;
      sda_hist <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_hist <= {scl_hist[1:0], scl_sync[1]};
      sda_hist <= {sda_hist[1:0], sda_sync[1]};
      if (hs_mode_o || (&scl_hist) || !(|scl_hist)) begin
        scl_f <= hs_mode_o ? scl_sync[1] : scl_hist[FILT_STD-1];
      end
      if (hs_mode_o || (&sda_hist) || !(|sda_hist)) begin
        sda_f <= hs_mode_o ? sda_sync[1] : sda_hist[FILT_STD-1];
      end
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_ev = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_ev  = scl_f & scl_d & ~sda_d & sda_f;

  // ==========================================================================
  // Byte engine
  slave_st_e  st;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [2:0] byte_idx;     // Bytes after address
  logic       ack_phase;
  logic       rd_dir;
  logic       addr_ok;
  logic [7:0] data_hi;
  logic [7:0] data_lo;
  logic       rd_lo;        // Byte being sent is lower byte
  logic       hs_pending;
  logic       ecc_flag;
  logic [7:0] upper_q;      // Bits 9:8 writable part
  logic [7:0] zone_q;
  logic [7:0] conf_q;       // Confirmation byte
  logic [15:0] word_now;

  function automatic logic is_cfg_addr(input logic [7:0] b, input logic [2:0] cs);
    // RL10 type id, RL11 chip selects
    is_cfg_addr = (b[7:4] == CFG_TYPE_ID) && (b[3:1] == cs);
  endfunction

  // Register word as read: RL16 unimplemented bits zero, RL15 flag on top
  function automatic logic [15:0] cfg_word(input logic ecc, input logic [7:0] up,
                                           input logic [7:0] zn);
    cfg_word = {ecc, 5'h00, up[SCHEME_BIT], up[LOCK_BIT], zn};
  endfunction
  assign word_now = cfg_word(ecc_flag, upper_q, zone_q);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st         <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      byte_idx   <= 3'h0;
      ack_phase  <= 1'b0;
      rd_dir     <= 1'b0;
      addr_ok    <= 1'b0;
      data_hi    <= 8'h00;
      data_lo    <= 8'h00;
      rd_lo      <= 1'b0;
      hs_pending <= 1'b0;
      conf_q     <= 8'h00;
      link.sda_s_oe <= 1'b0;
    end else if (stop_ev) begin
      st         <= ST_IDLE;
      hs_pending <= 1'b0;
      link.sda_s_oe <= 1'b0;
    end else if (start_ev) begin
      st        <= ST_ADDR;
      bit_cnt   <= 4'h0;
      ack_phase <= 1'b0;
      link.sda_s_oe <= 1'b0;
    end else begin
      case (st)
        ST_IDLE, ST_HSWT, ST_IGN: begin
          link.sda_s_oe <= 1'b0;
        end
        ST_ADDR, ST_RECV: begin
          if (scl_rise && !ack_phase) begin
            shreg   <= {shreg[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (scl_fall && !ack_phase && bit_cnt == 4'h8) begin
            ack_phase <= 1'b1;
            if (st == ST_ADDR) begin
              // RL1 master code, RL3 leave released, RL8 ignored while busy
              if (shreg[7:3] == HS_CODE_TOP) begin
                hs_pending    <= ~write_busy_i;
                link.sda_s_oe <= 1'b0;
              // RL5 ack address byte
              end else if (is_cfg_addr(shreg, chip_sel_i)) begin
                link.sda_s_oe <= 1'b1;
              end
            end else begin
              // RL22 acknowledged even when locked
              link.sda_s_oe <= 1'b1;
            end
          end else if (scl_fall && ack_phase) begin
            ack_phase     <= 1'b0;
            bit_cnt       <= 4'h0;
            link.sda_s_oe <= 1'b0;
            if (st == ST_ADDR) begin
              if (shreg[7:3] == HS_CODE_TOP) begin
                // RL4 wait for repeated start
                st <= ST_HSWT;
              end else if (is_cfg_addr(shreg, chip_sel_i)) begin
                rd_dir <= shreg[0];
                if (shreg[0]) begin
                  // RL13 read needs the word address first
                  st    <= addr_ok ? ST_SEND : ST_IGN;
                  rd_lo <= 1'b0;
                  link.sda_s_oe <= addr_ok & ~word_now[15];
                end else begin
                  st       <= ST_RECV;
                  byte_idx <= 3'h0;
                  addr_ok  <= 1'b0;
                end
              end else begin
                st <= ST_IGN;
              end
            end else begin
              byte_idx <= byte_idx + 3'h1;
              // RL12 check bits 15, 11, 10 only
              if (byte_idx == 3'h0) begin
                addr_ok <= shreg[WA_BIT_HI] & shreg[WA_BIT_MID] & ~shreg[WA_BIT_LO];
              end
              if (byte_idx == 3'h2) begin
                data_hi <= shreg;
              end
              if (byte_idx == 3'h3) begin
                data_lo <= shreg;
              end
              if (byte_idx == 3'h4) begin
                conf_q <= shreg;
              end
            end
          end
        end
        ST_SEND: begin
          // RL14 upper byte first, RL23 wrap on master ack
          if (scl_fall && !ack_phase) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h7) begin
              ack_phase     <= 1'b1;
              link.sda_s_oe <= 1'b0;
            end else begin
              link.sda_s_oe <= ~word_now[{~rd_lo, 3'h7 - bit_cnt[2:0] - 3'h1}];
            end
          end else if (scl_rise && ack_phase) begin
            if (sda_f) begin
              st <= ST_IGN;  // Master nack ends the read
            end
          end else if (scl_fall && ack_phase) begin
            ack_phase     <= 1'b0;
            bit_cnt       <= 4'h0;
            rd_lo         <= ~rd_lo;
            link.sda_s_oe <= ~word_now[{rd_lo, 3'h7}];
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // High-speed mode flag
  // RL4 enter after nacked code, RL6 leave on stop
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_mode_o <= 1'b0;
    end else if (stop_ev) begin
      hs_mode_o <= 1'b0;
    end else if (st == ST_HSWT && hs_pending) begin
      hs_mode_o <= 1'b1;
    end
  end

  // ==========================================================================
  // Update at stop; the clock rise before a stop shifts one stray bit
  logic commit;
  assign commit = stop_ev && st == ST_RECV && !rd_dir && byte_idx == 3'h5 && addr_ok
                  && bit_cnt <= 4'h1;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upper_q     <= UPPER_RESET;
      zone_q      <= ZONE_RESET;
      cfg_write_o <= 1'b0;
    end else begin
      cfg_write_o <= 1'b0;
      // RL20 exact count, RL21 matching pattern, RL18 RL22 locked stays
      if (commit && !upper_q[LOCK_BIT] &&
          ((data_hi[LOCK_BIT] && conf_q == CONFIRM_LOCK) ||
           (!data_hi[LOCK_BIT] && conf_q == CONFIRM_OPEN))) begin
        upper_q     <= {6'h00, data_hi[SCHEME_BIT], data_hi[LOCK_BIT]};
        zone_q      <= data_hi[SCHEME_BIT] ? data_lo : zone_q;
        cfg_write_o <= 1'b1;
      end
    end
  end

  // RL15 correction flag follows each array read
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ecc_flag <= 1'b0;
    end else if (mem_read_done_i) begin
      ecc_flag <= mem_read_ecc_i;
    end
  end

  // RL17 RL19 zone blocking from scheme, pin or zone bits
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zone_block_o <= 8'h00;
      cfg_word_o   <= 16'h0000;
    end else begin
      zone_block_o <= upper_q[SCHEME_BIT] ? zone_q : {8{wp_pin_i}};
      cfg_word_o   <= word_now;
    end
  end
endmodule : cfg_slave
`default_nettype wire

/* src/cfg_link_pkg.sv */
// Link constants: codes, register layout, timing.
// Assumes both ends run on sys_clk_i at 100 MHz.
package cfg_link_pkg;
  // ==========================================================================
  // Address and command codes
  localparam logic [4:0] HS_CODE_TOP      = 5'h01;   // Upper five bits 00001
  localparam logic [3:0] CFG_TYPE_ID      = 4'hb;    // Device type 1011
  localparam logic [7:0] CONFIRM_LOCK     = 8'h99;
  localparam logic [7:0] CONFIRM_OPEN     = 8'h66;
  localparam int         WA_BIT_HI        = 7;       // Bit 15
  localparam int         WA_BIT_MID       = 3;       // Bit 11
  localparam int         WA_BIT_LO        = 2;       // Bit 10
  // ==========================================================================
  // Register layout (upper byte)
  localparam int         ECC_BIT          = 7;
  localparam int         SCHEME_BIT       = 1;
  localparam int         LOCK_BIT         = 0;
  localparam logic [7:0] UPPER_RESET      = 8'h00;
  localparam logic [7:0] ZONE_RESET       = 8'h00;
  // ==========================================================================
  // Timing
  localparam int         SYS_CLK_MHZ      = 100;
  localparam int         SCL_STD_NS       = 1000;    // 1 MHz bus for master code
  localparam int         SCL_HS_NS        = 300;     // About 3.4 MHz bus
  localparam int         STD_HALF_CYC     = SCL_STD_NS * SYS_CLK_MHZ / 2000;
  localparam int         HS_HALF_CYC      = SCL_HS_NS * SYS_CLK_MHZ / 2000;
  localparam int         FILT_STD         = 3;       // Standard filter depth
endpackage : cfg_link_pkg

/* src/cfg_link_if.sv */
// Two-wire link between master and slave.
// Open-drain pins, levels resolved here.
`timescale 1ns/10ps
`default_nettype none
interface cfg_link_if;
  logic scl_m_oe;    // Master pulls clock low
  logic sda_m_oe;    // Master pulls data low
  logic sda_s_oe;    // Slave pulls data low
  logic scl;
  logic sda;
  // Wired-and with pull-ups
  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
  modport slave  (output sda_s_oe, input scl, input sda);
endinterface : cfg_link_if
`default_nettype wire

/* src/cfg_master.sv */
// Master end: high-speed entry, register reads and writes.
// Assumes the link resolves the open-drain wire.
`timescale 1ns/10ps
`default_nettype none
module cfg_master
  import cfg_link_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Two-wire link
  cfg_link_if.master       link,
  // Command port
  input  wire logic        cmd_valid_i,
  input  wire logic [1:0]  cmd_op_i,     // 0 hs entry, 1 read, 2 write
  input  wire logic [2:0]  cmd_cs_i,
  input  wire logic [15:0] cmd_data_i,
  input  wire logic        cmd_stop_i,   // End a high-speed command with stop instead of holding
  output logic             busy_o,
  output logic             done_o,
  output logic             nack_o,
  output logic [15:0]      rd_data_o
);
  // ==========================================================================
  // Byte sequencer: plays out a list of bytes with optional restart
  typedef enum logic [3:0] {
    MS_IDLE  = 4'b0001,
    MS_START = 4'b0010,
    MS_BITS  = 4'b0100,
    MS_STOP  = 4'b1000
  } mst_st_e;

  mst_st_e    st;
  logic [7:0] bytes [0:6];
  logic [2:0] n_bytes;
  logic [2:0] idx;
  logic [2:0] restart_at;
  logic [3:0] bit_n;
  logic [1:0] phase;
  logic [7:0] tick;
  logic [7:0] half;
  logic       hs;
  logic       is_read;
  logic [1:0] sda_s;
  logic [7:0] rx;

  // Sample the wire through two flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_s <= 2'h3;
    end else begin
      sda_s <= {sda_s[0], link.sda};
    end
  end

  // RL2 RL9 standard rate unless high speed; RL7 restarts
  assign half = hs ? 8'(HS_HALF_CYC) : 8'(STD_HALF_CYC);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= MS_IDLE; idx <= 3'h0; n_bytes <= 3'h0; restart_at <= 3'h7;
      bit_n <= 4'h0; phase <= 2'h0; tick <= 8'h00; hs <= 1'b0;
      is_read <= 1'b0; rx <= 8'h00; busy_o <= 1'b0; done_o <= 1'b0;
      nack_o <= 1'b0; rd_data_o <= 16'h0000;
      link.scl_m_oe <= 1'b0; link.sda_m_oe <= 1'b0;
      for (int i = 0; i < 7; i++) begin
        bytes[i] <= 8'h00;
      end
    end else begin
      done_o <= 1'b0;
      tick   <= (tick == half) ? 8'h00 : tick + 8'h01;
      case (st)
        MS_IDLE: begin
          if (cmd_valid_i) begin
            busy_o <= 1'b1; nack_o <= 1'b0; idx <= 3'h0; tick <= 8'h00;
            is_read <= (cmd_op_i == 2'h1);
            restart_at <= 3'h7;
            if (cmd_op_i == 2'h0) begin
              // RL1 master code, RL2 sent at standard rate
              bytes[0] <= {HS_CODE_TOP, 3'h0}; n_bytes <= 3'h1; hs <= 1'b0;
            end else begin
              // RL10 RL11 RL12 device address and word address
              bytes[0] <= {CFG_TYPE_ID, cmd_cs_i, 1'b0};
              bytes[1] <= 8'h88; bytes[2] <= 8'h00;
              if (cmd_op_i == 2'h1) begin
                // RL13 random read: restart then read address
                bytes[3] <= {CFG_TYPE_ID, cmd_cs_i, 1'b1};
                restart_at <= 3'h3; n_bytes <= 3'h6;
              end else begin
                // RL20 RL21 two bytes plus matching confirmation
                bytes[3] <= cmd_data_i[15:8]; bytes[4] <= cmd_data_i[7:0];
                bytes[5] <= cmd_data_i[8] ? CONFIRM_LOCK : CONFIRM_OPEN;
                n_bytes <= 3'h6;
              end
            end
            st <= MS_START; phase <= 2'h0;
          end
        end
        MS_START: begin
          if (tick == half) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: begin link.sda_m_oe <= 1'b0; link.scl_m_oe <= 1'b0; end
              2'h1: link.sda_m_oe <= 1'b1;
              default: begin link.scl_m_oe <= 1'b1; st <= MS_BITS; bit_n <= 4'h0;
                phase <= 2'h0; end
            endcase
          end
        end
        MS_BITS: begin
          if (tick == half) begin
            phase <= phase + 2'h1;
            if (phase == 2'h0) begin
              // Data moves while the clock is low
              if (bit_n < 4'h8) begin
                link.sda_m_oe <= (is_read && idx >= 3'h4) ? 1'b0 : ~bytes[idx][3'h7 - bit_n[2:0]];
              end else begin
                link.sda_m_oe <= (is_read && idx == 3'h4);
              end
            end else if (phase == 2'h1) begin
              link.scl_m_oe <= 1'b0;
            end else begin
              link.scl_m_oe <= 1'b1; phase <= 2'h0;
              if (bit_n < 4'h8) begin
                rx <= {rx[6:0], sda_s[1]};
                bit_n <= bit_n + 4'h1;
              end else begin
                bit_n <= 4'h0;
                if (is_read && idx == 3'h4) rd_data_o[15:8] <= rx;
                if (is_read && idx == 3'h5) rd_data_o[7:0] <= rx;
                if (!(is_read && idx >= 3'h4) && sda_s[1] && bytes[0][7:3] != HS_CODE_TOP) nack_o <= 1'b1;
                idx <= idx + 3'h1;
                if (idx + 3'h1 == n_bytes) begin
                  st <= MS_STOP;
                end else if (idx + 3'h1 == restart_at) begin
                  st <= MS_START; link.sda_m_oe <= 1'b0;
                end
              end
            end
          end
        end
        MS_STOP: begin
          if (tick == half) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: link.sda_m_oe <= (cmd_stop_i | ~hs) & (bytes[0][7:3] != HS_CODE_TOP);
              2'h1: link.scl_m_oe <= 1'b0;
              default: begin
                // RL6 stop drops high speed; the code leaves no stop behind
                link.sda_m_oe <= 1'b0;
                if (bytes[0][7:3] == HS_CODE_TOP) begin
                  hs <= 1'b1;
                end else if (cmd_stop_i) begin
                  hs <= 1'b0;
                end
                st <= MS_IDLE; busy_o <= 1'b0; done_o <= 1'b1; phase <= 2'h0;
              end
            endcase
          end
        end
        default: st <= MS_IDLE;
      endcase
    end
  end
endmodule : cfg_master
`default_nettype wire

/* tb/hs_entry_and_config_register_properties.sv */
// Wire checker for the link.
// Sees link signals only; the strap is a parameter.
`timescale 1ns/10ps
`default_nettype none
module hs_entry_and_config_register_properties
  import cfg_link_pkg::*;
#(parameter logic [2:0] CS = 3'h5)
(
  // Clock, reset and wire
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  // ==========================================================================
  // Frame decoding
  logic       prev_scl, prev_sda, hs_sess, frame_w, frame_r;
  logic [3:0] bit_cnt, byte_cnt;
  logic [7:0] shifter, data_hi, low_cnt, low_len;
  wire        start_ev = scl & prev_scl & prev_sda & ~sda;
  wire        stop_ev  = scl & prev_scl & ~prev_sda & sda;
  wire        scl_rise = scl & ~prev_scl;
  wire        ack_rise = scl_rise & (bit_cnt == 4'h8);
  // Idle high after reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
    end else begin
      prev_scl <= scl;
      prev_sda <= sda;
    end
  end
  // Bit and byte position
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt  <= 4'h0;
      byte_cnt <= 4'h0;
      shifter  <= 8'h00;
    end else if (start_ev | stop_ev) begin
      bit_cnt  <= 4'h0;
      byte_cnt <= 4'h0;
    end else if (ack_rise) begin
      bit_cnt  <= 4'h0;
      byte_cnt <= byte_cnt + 4'h1;
    end else if (scl_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
      shifter <= {shifter[6:0], sda};
    end
  end
  // Frame kind and session
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {frame_w, frame_r, hs_sess} <= 3'h0;
      data_hi <= 8'h00;
    end else if (stop_ev) begin
      hs_sess <= 1'b0;
    end else if (ack_rise && byte_cnt == 4'h0) begin
      frame_w <= (shifter == {CFG_TYPE_ID, CS, 1'b0});
      frame_r <= (shifter == {CFG_TYPE_ID, CS, 1'b1});
      hs_sess <= hs_sess | (shifter[7:3] == HS_CODE_TOP);
    end else if (ack_rise && byte_cnt == 4'h3) begin
      data_hi <= shifter;
    end
  end
  // Last clock-low length
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= 8'h00;
      low_len <= 8'h00;
    end else if (scl_rise) begin
      low_len <= low_cnt;
      low_cnt <= 8'h00;
    end else if (!scl && low_cnt != 8'hff) begin
      low_cnt <= low_cnt + 8'h1;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence byte_done(logic [3:0] n);
    ack_rise && byte_cnt == n;
  endsequence
  sequence code_byte;
    byte_done(4'h0) ##0 shifter[7:3] == HS_CODE_TOP;
  endsequence
  AST_CODE_NACK: assert property (code_byte |-> !sda_s_oe)
    else $error("code acked");
  AST_CODE_RATE: assert property (byte_done(4'h0) ##0 !hs_sess |-> low_len >= 8'd40)
    else $error("code too fast");
  AST_HS_RATE: assert property (byte_done(4'h0) ##0 hs_sess ##0
    shifter[7:3] != HS_CODE_TOP |-> low_len <= 8'd40)
    else $error("hs byte slow");
  AST_CFG_ACK: assert property (byte_done(4'h0) ##0 shifter[7:1] == {CFG_TYPE_ID, CS}
    |-> sda_s_oe)
    else $error("address not acked");
  AST_CS_MISS: assert property (byte_done(4'h0) ##0 shifter[7:4] == CFG_TYPE_ID
    ##0 shifter[3:1] != CS |-> !sda_s_oe)
    else $error("foreign select acked");
  AST_WORD_ADDR: assert property (byte_done(4'h1) ##0 frame_w
    |-> shifter[7] && shifter[3] && !shifter[2])
    else $error("bad word address");
  AST_CONFIRM: assert property (byte_done(4'h5) ##0 frame_w
    |-> shifter == (data_hi[0] ? CONFIRM_LOCK : CONFIRM_OPEN))
    else $error("bad confirm byte");
  AST_WRITE_ACK: assert property (ack_rise && frame_w && byte_cnt inside {[1:5]}
    |-> sda_s_oe)
    else $error("write byte not acked");
  AST_READ_END: assert property (byte_done(4'h2) ##0 frame_r |-> !sda_m_oe)
    else $error("read not ended");
endmodule : hs_entry_and_config_register_properties
`default_nettype wire

/* tb/test_hs_entry_and_config_register.sv */
// Bench: both ends joined by the link.
// Drives commands, straps and memory status.
`timescale 1ns/10ps
`default_nettype none
module test_hs_entry_and_config_register;
  import cfg_link_pkg::*;
  // ==========================================================================
  // Signals and instances
  localparam logic [2:0] STRAP = 3'h5;
  logic        sys_clk_i, rst_n_i, cmd_valid_i, cmd_stop_i, busy_o, done_o, nack_o;
  logic [1:0]  cmd_op_i;
  logic [2:0]  cmd_cs_i;
  logic [15:0] cmd_data_i, rd_data_o, cfg_word_o;
  logic        write_busy_i, mem_read_done_i, mem_read_ecc_i, wp_pin_i;
  logic        hs_mode_o, cfg_write_o;
  logic [7:0]  zone_block_o;
  int          err_count, cmp_count, wr_seen;
  cfg_link_if link ();
  cfg_master u_cfg_master (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(link),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_cs_i(cmd_cs_i),
    .cmd_data_i(cmd_data_i), .cmd_stop_i(cmd_stop_i), .busy_o(busy_o),
    .done_o(done_o), .nack_o(nack_o), .rd_data_o(rd_data_o));
  cfg_slave u_cfg_slave (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(link),
    .chip_sel_i(STRAP), .write_busy_i(write_busy_i), .mem_read_done_i(mem_read_done_i),
    .mem_read_ecc_i(mem_read_ecc_i), .wp_pin_i(wp_pin_i), .hs_mode_o(hs_mode_o),
    .zone_block_o(zone_block_o), .cfg_write_o(cfg_write_o), .cfg_word_o(cfg_word_o));
  hs_entry_and_config_register_properties #(.CS(STRAP))
    u_hs_entry_and_config_register_properties (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .scl_m_oe(link.scl_m_oe), .sda_m_oe(link.sda_m_oe),
    .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
  // Clock and commit pulse counter
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (cfg_write_o === 1'b1) wr_seen++;
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One command, bounded wait for done
  task automatic cmd(input logic [1:0] op, input logic [2:0] cs,
                     input logic [15:0] data, input logic stop);
    int n;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i    <= op;
    cmd_cs_i    <= cs;
    cmd_data_i  <= data;
    cmd_stop_i  <= stop;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      err_count++;
      $display("mismatch at %0t: command never done", $time);
    end
    repeat (20) @(posedge sys_clk_i);
  endtask
  // Array read report
  task automatic mem_read(input logic ecc);
    @(posedge sys_clk_i);
    mem_read_done_i <= 1'b1;
    mem_read_ecc_i  <= ecc;
    @(posedge sys_clk_i);
    mem_read_done_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    {sys_clk_i, rst_n_i, cmd_valid_i, cmd_stop_i, write_busy_i} = 5'h00;
    {mem_read_done_i, mem_read_ecc_i, wp_pin_i, cmd_op_i, cmd_cs_i} = 8'h00;
    cmd_data_i = 16'h0000;
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk(cfg_word_o, 16'h0000);
    cmd(2'h1, STRAP, 16'h0000, 1'b1);
    chk(rd_data_o, 16'h0000);
    // Read-only bits must not stick
    cmd(2'h2, STRAP, 16'hfea5, 1'b1);
    chk(16'(wr_seen), 16'h0001);
    chk(cfg_word_o, 16'h02a5);
    chk({8'h00, zone_block_o}, 16'h00a5);
    mem_read(1'b1);
    cmd(2'h1, STRAP, 16'h0000, 1'b1);
    chk(rd_data_o, 16'h82a5);
    mem_read(1'b0);
    chk(cfg_word_o, 16'h02a5);
    // Pin scheme
    cmd(2'h2, STRAP, 16'h00a5, 1'b1);
    chk(cfg_word_o, 16'h00a5);
    wp_pin_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    chk({8'h00, zone_block_o}, 16'h00ff);
    wp_pin_i <= 1'b0;
    // Entry refused while writing
    write_busy_i <= 1'b1;
    cmd(2'h0, STRAP, 16'h0000, 1'b1);
    chk(hs_mode_o, 16'h0000);
    write_busy_i <= 1'b0;
    cmd(2'h0, STRAP, 16'h0000, 1'b0);
    chk(hs_mode_o, 16'h0001);
    // Restart chain, then stop
    cmd(2'h1, STRAP, 16'h0000, 1'b0);
    chk(rd_data_o, 16'h00a5);
    chk(hs_mode_o, 16'h0001);
    cmd(2'h1, STRAP, 16'h0000, 1'b1);
    chk(hs_mode_o, 16'h0000);
    cmd(2'h1, 3'h2, 16'h0000, 1'b1);
    chk(nack_o, 16'h0001);
    // Lock, then a refused write
    cmd(2'h2, STRAP, 16'h03f0, 1'b1);
    chk({nack_o, cfg_word_o[14:0]}, 16'h03f0);
    chk(16'(wr_seen), 16'h0003);
    cmd(2'h2, STRAP, 16'h0200, 1'b1);
    chk({nack_o, cfg_word_o[14:0]}, 16'h03f0);
    chk(16'(wr_seen), 16'h0003);
    // Reset mid-session
    cmd(2'h0, STRAP, 16'h0000, 1'b0);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    chk(hs_mode_o, 16'h0000);
    close_out();
  end
  // Watchdog beyond the test span
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : test_hs_entry_and_config_register
`default_nettype wire
